// ---- rtl/dcq_consts.svh ----
// Constants for the debug comparator qualifier: window offsets, control
// field positions, writable masks and reset values.
// Assumes inclusion by the top module only.
`ifndef DCQ_CONSTS_SVH
`define DCQ_CONSTS_SVH

// Byte offsets of the comparator window within the debug register map.
`define DCQ_OFS_CTL 8'h28
`define DCQ_OFS_AHI 8'h29
`define DCQ_OFS_WIN_LAST 8'h2F

// Control register field positions.
`define DCQ_BIT_SIZE_EN 7
`define DCQ_BIT_INV_DATA 6
`define DCQ_BIT_SIZE_VAL 6
`define DCQ_BIT_TAG 5
`define DCQ_BIT_BREAK 4
`define DCQ_BIT_RW_VAL 3
`define DCQ_BIT_RW_EN 2
`define DCQ_BIT_ENABLE 0

// Writable bits of each control register; all others read as zero.
`define DCQ_CTL_WMASK_A 8'h7D
`define DCQ_CTL_WMASK_B 8'hFD
`define DCQ_CTL_WMASK_C 8'h3D

// Reset values.
`define DCQ_CTL_RESET 8'h00
`define DCQ_AHI_RESET 2'h0
`define DCQ_RDATA_RESET 8'h00

`endif

// ---- rtl/dcq_pkg.sv ----
// Types shared by the debug comparator qualifier.
// Assumes the constants header sits beside this file.
package dcq_pkg;

   // Comparator-select field from the main debug control register.
   typedef enum logic [1:0] {
      DCQ_SEL_A = 2'h0,
      DCQ_SEL_B = 2'h1,
      DCQ_SEL_C = 2'h2,
      DCQ_SEL_NONE = 2'h3
   } dcq_sel_type;

   // Number of comparator channels.
   localparam int DCQ_CHANNELS = 3;

endpackage : dcq_pkg

// ---- rtl/dcq_top.sv ----
// Debug comparator qualifier: control and high address compare registers
// for comparators A, B and C, and qualification of their bus matches.
// Assumes every input is driven by logic on clk_sys; the mid, low and data
// compare results arrive already computed from neighbouring logic.
`timescale 1ns/10ps
`include "dcq_consts.svh"

module dcq_top (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Main debug control state.
   input wire dcq_pkg::dcq_sel_type comparator_select,
   input wire logic armed,
   input wire logic global_breakpoint_enable,
   // Monitored core bus.
   input wire logic bus_access,
   input wire logic [1:0] bus_addr_high,
   input wire logic bus_rw,
   input wire logic bus_byte,
   input wire logic [2:0] addr_low_match,
   input wire logic data_equal,
   input wire logic [2:0] tag_exec,
   // Qualified results.
   output logic [2:0] cmp_match,
   output logic [2:0] tag_request,
   output logic session_end,
   output logic disarm_req,
   output logic breakpoint
);
   import dcq_pkg::*;

   logic [7:0] ctl_r [0:2];
   logic [1:0] ahi_r [0:2];
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [2:0] match_r;
   logic [2:0] match_nxt;
   logic [2:0] tagreq_r;
   logic [2:0] tagreq_nxt;
   logic end_r;
   logic disarm_r;
   logic bp_r;
   logic break_hit;
   logic wr_ok;

   // Channel index of the selected comparator, valid unless none is shown.
   function automatic int sel_idx(input dcq_sel_type s);
      sel_idx = int'(s);
   endfunction

   // Writable bits of a channel's control register.
   function automatic logic [7:0] ctl_wmask(input int ch);
      case (ch)
         0: ctl_wmask = `DCQ_CTL_WMASK_A;
         1: ctl_wmask = `DCQ_CTL_WMASK_B;
         default: ctl_wmask = `DCQ_CTL_WMASK_C;
      endcase
   endfunction

   // A write lands only when a comparator is shown and the module is idle.
   // armed gates writes
   assign wr_ok = reg_wr && !armed && (comparator_select != DCQ_SEL_NONE);

   // Control registers; only the selected one can take a write.
   // selected control write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DCQ_CHANNELS; i++) begin
            ctl_r[i] <= `DCQ_CTL_RESET;
         end
      end else if (wr_ok && reg_addr == `DCQ_OFS_CTL) begin
         for (int i = 0; i < DCQ_CHANNELS; i++) begin
            if (sel_idx(comparator_select) == i) begin
               ctl_r[i] <= reg_wdata & ctl_wmask(i);
            end
         end
      end
   end

   // High address compare registers, two bits each.
   // high address bits
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DCQ_CHANNELS; i++) begin
            ahi_r[i] <= `DCQ_AHI_RESET;
         end
      end else if (wr_ok && reg_addr == `DCQ_OFS_AHI) begin
         for (int i = 0; i < DCQ_CHANNELS; i++) begin
            if (sel_idx(comparator_select) == i) begin
               ahi_r[i] <= reg_wdata[1:0];
            end
         end
      end
   end

   // Read mux; any other byte, or no comparator shown, reads as zero.
   // window visibility
   always_comb begin
      rdata_nxt = `DCQ_RDATA_RESET;
      if (reg_rd && comparator_select != DCQ_SEL_NONE) begin
         if (reg_addr == `DCQ_OFS_CTL) begin
            rdata_nxt = ctl_r[sel_idx(comparator_select)];
         end else if (reg_addr == `DCQ_OFS_AHI) begin
            rdata_nxt = {6'h00, ahi_r[sel_idx(comparator_select)]};
         end
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_r <= `DCQ_RDATA_RESET;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Match qualification for each channel. A tagged channel only asks for a
   // tag and then fires when the opcode executes, so direction, size and
   // data are deliberately ignored on that path.
   always_comb begin
      match_nxt = 3'h0;
      tagreq_nxt = 3'h0;
      for (int i = 0; i < DCQ_CHANNELS; i++) begin
         logic raw;
         logic ok;
         raw = 1'b0;
         ok = 1'b1;
         raw = ctl_r[i][`DCQ_BIT_ENABLE] && bus_access && (bus_addr_high == ahi_r[i]) && addr_low_match[i];
         if (ctl_r[i][`DCQ_BIT_RW_EN] && (bus_rw != ctl_r[i][`DCQ_BIT_RW_VAL])) begin
            ok = 1'b0;
         end
         if (i == 1 && ctl_r[i][`DCQ_BIT_SIZE_EN] && (bus_byte != ctl_r[i][`DCQ_BIT_SIZE_VAL])) begin
            ok = 1'b0;
         end
         if (i == 0 && (data_equal == ctl_r[i][`DCQ_BIT_INV_DATA])) begin
            ok = 1'b0;
         end
         if (ctl_r[i][`DCQ_BIT_TAG]) begin
            tagreq_nxt[i] = raw;
            match_nxt[i] = ctl_r[i][`DCQ_BIT_ENABLE] && tag_exec[i];
         end else begin
            match_nxt[i] = raw && ok;
         end
      end
   end

   // Any firing channel with break set ends the session at once.
   // break ends session
   always_comb begin
      break_hit = 1'b0;
      for (int i = 0; i < DCQ_CHANNELS; i++) begin
         if (match_nxt[i] && ctl_r[i][`DCQ_BIT_BREAK]) begin
            break_hit = 1'b1;
         end
      end
   end

   // Registered match and tag pulses toward the sequencer and queue.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         match_r <= 3'h0;
         tagreq_r <= 3'h0;
      end else begin
         match_r <= match_nxt;
         tagreq_r <= tagreq_nxt;
      end
   end

   // Session end and disarm follow a break hit; the breakpoint itself is
   // withheld unless breakpoints are enabled globally.
   // break disarm
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         end_r <= 1'b0;
         disarm_r <= 1'b0;
         bp_r <= 1'b0;
      end else begin
         end_r <= break_hit;
         disarm_r <= break_hit;
         bp_r <= break_hit && global_breakpoint_enable;
      end
   end

   assign reg_rdata = rdata_r;
   assign cmp_match = match_r;
   assign tag_request = tagreq_r;
   assign session_end = end_r;
   assign disarm_req = disarm_r;
   assign breakpoint = bp_r;

   // Checks on the block's registers and outputs. They run on the one clock and are
   // silenced during reset, when every register is forced to its idle value.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_armed_ctl_hold: assert property ((reg_wr && armed)
      |=> ($stable(ctl_r[0]) && $stable(ctl_r[1]) && $stable(ctl_r[2])))
      else $error("control register changed while armed");

   a_armed_ahi_hold: assert property ((reg_wr && armed)
      |=> ($stable(ahi_r[0]) && $stable(ahi_r[1]) && $stable(ahi_r[2])))
      else $error("high address register changed while armed");

   a_read_ctl_a: assert property ((reg_rd && reg_addr == `DCQ_OFS_CTL && comparator_select == DCQ_SEL_A)
      |=> reg_rdata == $past(ctl_r[0]))
      else $error("control read does not show comparator A");

   a_read_ctl_b: assert property ((reg_rd && reg_addr == `DCQ_OFS_CTL && comparator_select == DCQ_SEL_B)
      |=> reg_rdata == $past(ctl_r[1]))
      else $error("control read does not show comparator B");

   a_read_none_zero: assert property ((reg_rd && comparator_select == DCQ_SEL_NONE)
      |=> reg_rdata == 8'h00)
      else $error("window not empty with no comparator selected");

   a_unimpl_zero: assert property ((reg_rd && reg_addr > `DCQ_OFS_AHI && reg_addr <= `DCQ_OFS_WIN_LAST)
      |=> reg_rdata == 8'h00)
      else $error("unimplemented window byte not zero");

   a_read_idle_zero: assert property (!reg_rd
      |=> reg_rdata == 8'h00)
      else $error("read data outside the cycle after a read");

   a_ahi_upper_zero: assert property ((reg_rd && reg_addr == `DCQ_OFS_AHI)
      |=> reg_rdata[7:2] == 6'h00)
      else $error("high address read shows bits above its two");

   a_c_top_bits: assert property ((ctl_r[2][7:6] == 2'h0)
      && (ctl_r[0][7] == 1'b0))
      else $error("reserved control bit set");

   a_disabled_quiet: assert property (!ctl_r[1][`DCQ_BIT_ENABLE]
      |=> !cmp_match[1])
      else $error("disabled comparator matched");

   a_rw_mismatch: assert property ((ctl_r[0][`DCQ_BIT_RW_EN] && !ctl_r[0][`DCQ_BIT_TAG]
      && bus_rw != ctl_r[0][`DCQ_BIT_RW_VAL]) |=> !cmp_match[0])
      else $error("direction mismatch matched");

   a_size_mismatch: assert property ((ctl_r[1][`DCQ_BIT_SIZE_EN] && !ctl_r[1][`DCQ_BIT_TAG]
      && bus_byte != ctl_r[1][`DCQ_BIT_SIZE_VAL]) |=> !cmp_match[1])
      else $error("size mismatch matched");

   a_data_sense: assert property ((!ctl_r[0][`DCQ_BIT_TAG] && data_equal == ctl_r[0][`DCQ_BIT_INV_DATA])
      |=> !cmp_match[0])
      else $error("data sense wrong on comparator A");

   a_tag_wait: assert property ((ctl_r[2][`DCQ_BIT_TAG] && !tag_exec[2])
      |=> !cmp_match[2])
      else $error("tagged channel fired before execution");

   a_tag_request: assert property ((ctl_r[2][`DCQ_BIT_TAG] && ctl_r[2][`DCQ_BIT_ENABLE] && bus_access
      && bus_addr_high == ahi_r[2] && addr_low_match[2]) |=> tag_request[2])
      else $error("tagged channel did not request a tag");

   a_untag_quiet: assert property (!ctl_r[0][`DCQ_BIT_TAG]
      |=> !tag_request[0])
      else $error("untagged channel requested a tag");

   a_tag_fires: assert property ((ctl_r[1][`DCQ_BIT_TAG] && ctl_r[1][`DCQ_BIT_ENABLE] && tag_exec[1])
      |=> cmp_match[1])
      else $error("tagged channel missed its execution");

   a_break_gate: assert property (breakpoint
      |-> (session_end && $past(global_breakpoint_enable)))
      else $error("breakpoint without global enable");

   a_break_pass: assert property ((session_end && $past(global_breakpoint_enable))
      |-> breakpoint)
      else $error("enabled break gave no breakpoint");

   a_break_disarm: assert property ((cmp_match[0] && $past(ctl_r[0][`DCQ_BIT_BREAK]))
      |-> (session_end && disarm_req))
      else $error("break match did not end session");

   a_break_chan_c: assert property ((cmp_match[2] && $past(ctl_r[2][`DCQ_BIT_BREAK]))
      |-> (session_end && disarm_req))
      else $error("tagged break match did not end session");

   // Main scenarios worth seeing at least once.
   c_tag_fire: cover property (tag_request[2] ##[1:8] cmp_match[2]);
   c_break_bp: cover property (breakpoint);
   c_read_after_write: cover property ((reg_wr && !armed) ##2 reg_rd ##1 reg_rdata != 8'h00);
   c_armed_write: cover property (reg_wr && armed);
   c_size_match: cover property (ctl_r[1][`DCQ_BIT_SIZE_EN] && !ctl_r[1][`DCQ_BIT_TAG] ##1 cmp_match[1]);

endmodule // dcq_top

// ---- verif/dcq_bus_model.sv ----
// Model of the monitored core bus and its external address/data comparators.
// Assumes the caller invokes cycle() from one process, clocked by clk_sys.
`timescale 1ns/10ps

module dcq_bus_model (
   // Clock.
   input wire logic clk_sys,
   // Core bus towards the qualifier.
   output logic bus_access,
   output logic [1:0] bus_addr_high,
   output logic bus_rw,
   output logic bus_byte,
   output logic [2:0] addr_low_match,
   output logic data_equal,
   output logic [2:0] tag_exec
);
   // Idle bus at time zero.
   initial begin
      bus_access = 1'b0;
      bus_addr_high = 2'h0;
      bus_rw = 1'b0;
      bus_byte = 1'b0;
      addr_low_match = 3'h0;
      data_equal = 1'b0;
      tag_exec = 3'h0;
   end

   // One bus cycle; afterwards the address-high, direction and size lines show the inverse of the last value
   // and the other lines drop to zero, so a design that samples them outside a cycle cannot pass by luck.
   task automatic cycle(input logic acc, input logic [1:0] ah, input logic rw, input logic byt,
                        input logic [2:0] lm, input logic de, input logic [2:0] te);
      @(posedge clk_sys);
      bus_access <= acc;
      bus_addr_high <= ah;
      bus_rw <= rw;
      bus_byte <= byt;
      addr_low_match <= lm;
      data_equal <= de;
      tag_exec <= te;
      @(posedge clk_sys);
      bus_access <= 1'b0;
      bus_addr_high <= ~ah;
      bus_rw <= ~rw;
      bus_byte <= ~byt;
      addr_low_match <= 3'h0;
      data_equal <= 1'b0;
      tag_exec <= 3'h0;
   endtask
endmodule // dcq_bus_model

// ---- verif/tb_debug_comparator_qualifier.sv ----
// Self-checking bench for the debug comparator qualifier.
// Assumes the design files under rtl/ and the bus model are compiled first.
`timescale 1ns/10ps

module tb_debug_comparator_qualifier;
   import dcq_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   dcq_sel_type sel = DCQ_SEL_A;
   logic armed = 1'b0;
   logic gbe = 1'b0;
   logic bus_access, bus_rw, bus_byte, data_equal, session_end, disarm_req, breakpoint;
   logic [1:0] bus_addr_high;
   logic [2:0] addr_low_match, tag_exec, cmp_match, tag_request;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;

   // Clock at 50 MHz.
   always #10 clk_sys = ~clk_sys;

   dcq_bus_model bus_u (.clk_sys(clk_sys), .bus_access(bus_access), .bus_addr_high(bus_addr_high),
      .bus_rw(bus_rw), .bus_byte(bus_byte), .addr_low_match(addr_low_match), .data_equal(data_equal),
      .tag_exec(tag_exec));

   dcq_top dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comparator_select(sel), .armed(armed),
      .global_breakpoint_enable(gbe), .bus_access(bus_access), .bus_addr_high(bus_addr_high),
      .bus_rw(bus_rw), .bus_byte(bus_byte), .addr_low_match(addr_low_match), .data_equal(data_equal),
      .tag_exec(tag_exec), .cmp_match(cmp_match), .tag_request(tag_request), .session_end(session_end),
      .disarm_req(disarm_req), .breakpoint(breakpoint));

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Hang guard: 3000 cycles is ample for this sequence of under two hundred.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are sampled there.
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", {1'b0, exp}, {1'b0, reg_rdata});
   endtask

   task automatic pick(input dcq_sel_type s);
      @(posedge clk_sys);
      sel <= s;
   endtask

   // One bus cycle, then the qualified outputs one cycle later.
   task automatic bus(input logic acc, input logic [1:0] ah, input logic rw, input logic byt,
                      input logic [2:0] lm, input logic de, input logic [2:0] te, input logic [8:0] exp);
      bus_u.cycle(acc, ah, rw, byt, lm, de, te);
      #1;
      chk("match_outputs", exp, {cmp_match, tag_request, session_end, disarm_req, breakpoint});
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, writable masks and the unimplemented window bytes.
      for (int s = 0; s < 3; s++) begin
         pick(dcq_sel_type'(s));
         rd(8'h28, 8'h00);
         rd(8'h29, 8'h00);
         wr(8'h28, 8'hFF);
         wr(8'h29, 8'hFF);
         rd(8'h28, (s == 0) ? 8'h7D : (s == 1) ? 8'hFD : 8'h3D);
         rd(8'h29, 8'h03);
         rd(8'h2A, 8'h00);
         wr(8'h2C, 8'h5A);
         rd(8'h2C, 8'h00);
      end
      pick(DCQ_SEL_NONE);
      wr(8'h28, 8'h01);
      rd(8'h28, 8'h00);
      rd(8'h29, 8'h00);
      // Writes while armed leave everything unchanged; reads still work.
      pick(DCQ_SEL_A);
      armed <= 1'b1;
      wr(8'h28, 8'h15);
      wr(8'h29, 8'h02);
      rd(8'h28, 8'h7D);
      rd(8'h29, 8'h03);
      bus(0, 2'h0, 0, 0, 3'b000, 0, 3'b001, 9'b001_000_110);
      @(posedge clk_sys);
      armed <= 1'b0;
      wr(8'h28, 8'h14);
      wr(8'h29, 8'h02);
      bus(1, 2'h2, 0, 0, 3'b001, 1, 3'b000, 9'h000);
      wr(8'h28, 8'h15);
      bus(1, 2'h2, 0, 0, 3'b001, 1, 3'b000, 9'b001_000_110);
      @(posedge clk_sys);
      gbe <= 1'b1;
      bus(1, 2'h2, 0, 0, 3'b001, 1, 3'b000, 9'b001_000_111);
      bus(1, 2'h1, 0, 0, 3'b001, 1, 3'b000, 9'h000);
      wr(8'h28, 8'h41);
      bus(1, 2'h2, 1, 0, 3'b001, 0, 3'b000, 9'b001_000_000);
      bus(1, 2'h2, 1, 0, 3'b001, 1, 3'b000, 9'h000);
      // Comparator B: direction and size qualification.
      pick(DCQ_SEL_B);
      wr(8'h29, 8'h00);
      wr(8'h28, 8'h0D);
      bus(1, 2'h0, 1, 0, 3'b010, 0, 3'b000, 9'b010_000_000);
      bus(1, 2'h0, 0, 0, 3'b010, 0, 3'b000, 9'h000);
      wr(8'h28, 8'h05);
      bus(1, 2'h0, 0, 1, 3'b010, 0, 3'b000, 9'b010_000_000);
      wr(8'h28, 8'h81);
      bus(1, 2'h0, 1, 1, 3'b010, 0, 3'b000, 9'h000);
      bus(1, 2'h0, 1, 0, 3'b010, 0, 3'b000, 9'b010_000_000);
      wr(8'h28, 8'hC1);
      bus(1, 2'h0, 0, 1, 3'b010, 0, 3'b000, 9'b010_000_000);
      wr(8'h28, 8'hAD);
      bus(1, 2'h0, 0, 0, 3'b010, 0, 3'b000, 9'b000_010_000);
      bus(0, 2'h0, 0, 0, 3'b000, 0, 3'b010, 9'b010_000_000);
      // Comparator C: tagged break fires only on execution.
      pick(DCQ_SEL_C);
      wr(8'h29, 8'h01);
      wr(8'h28, 8'h31);
      bus(1, 2'h1, 1, 0, 3'b100, 0, 3'b000, 9'b000_100_000);
      bus(0, 2'h0, 0, 0, 3'b000, 0, 3'b100, 9'b100_000_111);
      tally_and_finish();
   end
endmodule // tb_debug_comparator_qualifier
